// *** hw/dcpc_top.sv ***
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - each of the four channels is powered up or down on its own by its power-up bit.
// - after reset all power-up bits are clear and every channel is powered down.
// - a powered-down channel has its ground clamp closed and its amplifier disconnected.
// - at supply power-up outputs stay clamped until supplies are good and a valid word is written.
// - the clamp enable bit of the control register selects current clamp or auto power-down.
// - with clamp enable 1 a short limits current, sets the overcurrent flag and keeps power.
// - in clamp mode the overcurrent flag clears by itself once the short is gone.
// - with clamp enable 0 a short powers the channel down, sets its flag and clears its power-up bit.
// - thermal shutdown is off after reset and acts only once its enable bit is set.
// - with thermal shutdown on, overtemperature shuts outputs down and sets the thermal flag.
// - the power control register has select code 010 and holds power-up bits and read-only flags.
// - thermal shutdown powers down all four channels at once; its flag is read-only.
module dcpc_top
	import dcpc_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = PU_CYCLES
)(
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// asynchronous analog sense
	input  wire logic [3:0]  chan_short_in,
	input  wire logic        overtemp_in,
	input  wire logic        supplies_good_in,
	// analog switch controls
	output logic [3:0]       amp_connect_switch_out,
	output logic [3:0]       output_ground_clamp_out,
	output logic [3:0]       current_limit_out,
	output logic [3:0]       chan_ready_out,
	// interrupt
	output logic             irq_out
);
	// register layout packs exactly four channels
	if (NUM_CHAN != 4)
	begin : g_bad_chan
		$error("dcpc_top: four channels expected");
	end
	if (SETTLE_CYCLES < 1)
	begin : g_bad_settle
		$error("dcpc_top: SETTLE_CYCLES must be at least one");
	end

	typedef enum logic [1:0] {DCPC_IDLE, DCPC_RESP} dcpc_bus_t;

	// synchronised sense inputs
	logic [3:0] short_s;
	logic [1:0] misc_s;
	dcpc_sync #(.WIDTH(4)) u_sync_short (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.async_in  (chan_short_in),
		.sync_out  (short_s)
	);
	dcpc_sync #(.WIDTH(2)) u_sync_misc (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.async_in  ({supplies_good_in, overtemp_in}),
		.sync_out  (misc_s)
	);

	// register state
	logic [3:0]           pu_reg, pu_next;
	logic [3:0]           oc_reg, oc_next;
	logic                 therm_reg, therm_next;
	logic                 clamp_en_reg, clamp_en_next;
	logic                 therm_en_reg, therm_en_next;
	logic                 word_seen_reg, word_seen_next;
	logic [IRQ_WIDTH-1:0] ists_reg, ists_next;
	logic [IRQ_WIDTH-1:0] imask_reg, imask_next;
	logic [3:0]           amp_reg, amp_next;
	logic [3:0]           gnd_reg, gnd_next;
	logic [3:0]           lim_reg, lim_next;
	logic                 irq_reg, irq_next;

	// bus state
	dcpc_bus_t            wst_reg, wst_next, rst_reg, rst_next;
	logic                 aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [7:0]           waddr_reg, waddr_next;
	logic [31:0]          wdata_reg, wdata_next;
	logic [3:0]           wstrb_reg, wstrb_next;
	logic [1:0]           bresp_reg, bresp_next;
	logic [31:0]          rdata_reg, rdata_next;
	logic [1:0]           rresp_reg, rresp_next;

	logic                 wr_fire;
	logic                 rd_fire;
	logic [3:0]           settled;

	function automatic logic [31:0] pwr_word(input logic [3:0] oc, input logic th, input logic [3:0] pu);
		logic [31:0] v;
		v = '0;
		v[PWR_OC_LSB +: 4] = oc;
		v[PWR_THERM_BIT]   = th;
		v[PWR_PU_LSB +: 4] = pu;
		return v;
	endfunction : pwr_word

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] v;
		v = old;
		for (int b = 0; b < 4; b++)
		begin
			if (st[b])
				v[b*8 +: 8] = nw[b*8 +: 8];
		end
		return v;
	endfunction : merge

	assign wr_fire = (wst_reg == DCPC_IDLE) && aw_got_reg && w_got_reg;
	assign rd_fire = (rst_reg == DCPC_IDLE) && s_axi_arvalid_in;

	// write channel: address and data taken in either order
	always_comb
	begin
		wst_next    = wst_reg;
		aw_got_next = aw_got_reg;
		w_got_next  = w_got_reg;
		waddr_next  = waddr_reg;
		wdata_next  = wdata_reg;
		wstrb_next  = wstrb_reg;
		bresp_next  = bresp_reg;
		case (wst_reg)
			DCPC_IDLE:
			begin
				if (s_axi_awvalid_in && !aw_got_reg)
				begin
					aw_got_next = 1'b1;
					waddr_next  = s_axi_awaddr_in;
				end
				if (s_axi_wvalid_in && !w_got_reg)
				begin
					w_got_next = 1'b1;
					wdata_next = s_axi_wdata_in;
					wstrb_next = s_axi_wstrb_in;
				end
				if (wr_fire)
				begin
					wst_next    = DCPC_RESP;
					aw_got_next = 1'b0;
					w_got_next  = 1'b0;
					case (waddr_reg)
						ADDR_PWR_CTRL, ADDR_CTRL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_DAC_WORD:
							bresp_next = RESP_OKAY;
						default:
							bresp_next = RESP_SLVERR;
					endcase
				end
			end
			DCPC_RESP:
			begin
				if (s_axi_bready_in)
					wst_next = DCPC_IDLE;
			end
			default:
				wst_next = DCPC_IDLE;
		endcase
	end

	// read channel
	always_comb
	begin
		rst_next   = rst_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		case (rst_reg)
			DCPC_IDLE:
			begin
				if (s_axi_arvalid_in)
				begin
					rst_next   = DCPC_RESP;
					rresp_next = RESP_OKAY;
					case (s_axi_araddr_in)
						ADDR_PWR_CTRL:   rdata_next = pwr_word(oc_reg, therm_reg, pu_reg);
						ADDR_CTRL:       rdata_next = 32'({clamp_en_reg, therm_en_reg, 2'b00});
						ADDR_IRQ_STATUS: rdata_next = 32'(ists_reg);
						ADDR_IRQ_MASK:   rdata_next = 32'(imask_reg);
						ADDR_DAC_WORD:   rdata_next = 32'(word_seen_reg);
						default:
						begin
							rdata_next = '0;
							rresp_next = RESP_SLVERR;
						end
					endcase
				end
			end
			DCPC_RESP:
			begin
				if (s_axi_rready_in)
					rst_next = DCPC_IDLE;
			end
			default:
				rst_next = DCPC_IDLE;
		endcase
	end

	// protection and register file
	always_comb
	begin
		logic [31:0] wv;
		logic [IRQ_WIDTH-1:0] ev;
		logic trip;
		wv             = '0;
		ev             = '0;
		trip           = 1'b0;
		pu_next        = pu_reg;
		clamp_en_next  = clamp_en_reg;
		therm_en_next  = therm_en_reg;
		word_seen_next = word_seen_reg;
		imask_next     = imask_reg;
		therm_next     = therm_reg;
		ists_next      = ists_reg;
		if (wr_fire)
		begin
			case (waddr_reg)
				ADDR_PWR_CTRL:
				begin
					// flags are read-only; only power-up bits are writable
					wv      = merge(pwr_word(oc_reg, therm_reg, pu_reg), wdata_reg, wstrb_reg);
					pu_next = wv[PWR_PU_LSB +: 4];
					word_seen_next = word_seen_reg | misc_s[1];
				end
				ADDR_CTRL:
				begin
					wv            = merge(CTRL_RESET, wdata_reg, wstrb_reg);
					clamp_en_next = wv[CTRL_CLAMP_EN_BIT];
					therm_en_next = wv[CTRL_THERM_EN_BIT];
					word_seen_next = word_seen_reg | misc_s[1];
				end
				ADDR_IRQ_MASK:
				begin
					wv         = merge(32'(imask_reg), wdata_reg, wstrb_reg);
					imask_next = wv[IRQ_WIDTH-1:0];
				end
				ADDR_DAC_WORD:
					word_seen_next = word_seen_reg | misc_s[1];
				default:
					wv = '0;
			endcase
		end
		// supply loss re-arms the power-up clamp
		if (!misc_s[1])
			word_seen_next = 1'b0;
		// overcurrent: flag follows the short in clamp mode; auto power-down latches pu low
		oc_next = short_s & (clamp_en_reg ? 4'hF : pu_reg);
		if (!clamp_en_reg)
		begin
			oc_next = oc_reg | (short_s & pu_reg);
			oc_next = oc_next & ~(pu_next & ~pu_reg); // re-power clears the old flag
			pu_next = pu_next & ~(short_s & pu_reg);
		end
		trip = therm_en_reg && misc_s[0];
		if (trip)
		begin
			therm_next = 1'b1;
			pu_next    = 4'h0;
		end
		else if (!misc_s[0])
			therm_next = 1'b0;
		ev = {trip & ~therm_reg, oc_next & ~oc_reg};
		if (rd_fire && s_axi_araddr_in == ADDR_IRQ_STATUS)
			ists_next = ev; // set wins over the read clear
		else
			ists_next = ists_reg | ev;
		// switches: connect only when powered and the power-up clamp is released
		amp_next  = pu_reg & {4{word_seen_reg & misc_s[1] & ~therm_reg}};
		gnd_next  = ~amp_next;
		lim_next  = short_s & pu_reg & {4{clamp_en_reg}};
		irq_next  = |(ists_reg & imask_reg);
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			pu_reg        <= 4'h0;
			oc_reg        <= 4'h0;
			therm_reg     <= 1'b0;
			clamp_en_reg  <= CTRL_RESET[CTRL_CLAMP_EN_BIT];
			therm_en_reg  <= CTRL_RESET[CTRL_THERM_EN_BIT];
			word_seen_reg <= 1'b0;
			ists_reg      <= '0;
			imask_reg     <= '0;
			amp_reg       <= 4'h0;
			gnd_reg       <= 4'hF;
			lim_reg       <= 4'h0;
			irq_reg       <= 1'b0;
			wst_reg       <= DCPC_IDLE;
			rst_reg       <= DCPC_IDLE;
			aw_got_reg    <= 1'b0;
			w_got_reg     <= 1'b0;
			waddr_reg     <= '0;
			wdata_reg     <= '0;
			wstrb_reg     <= '0;
			bresp_reg     <= RESP_OKAY;
			rdata_reg     <= '0;
			rresp_reg     <= RESP_OKAY;
		end
		else
		begin
			pu_reg        <= pu_next;
			oc_reg        <= oc_next;
			therm_reg     <= therm_next;
			clamp_en_reg  <= clamp_en_next;
			therm_en_reg  <= therm_en_next;
			word_seen_reg <= word_seen_next;
			ists_reg      <= ists_next;
			imask_reg     <= imask_next;
			amp_reg       <= amp_next;
			gnd_reg       <= gnd_next;
			lim_reg       <= lim_next;
			irq_reg       <= irq_next;
			wst_reg       <= wst_next;
			rst_reg       <= rst_next;
			aw_got_reg    <= aw_got_next;
			w_got_reg     <= w_got_next;
			waddr_reg     <= waddr_next;
			wdata_reg     <= wdata_next;
			wstrb_reg     <= wstrb_next;
			bresp_reg     <= bresp_next;
			rdata_reg     <= rdata_next;
			rresp_reg     <= rresp_next;
		end
	end

	// settle timers gate the ready indication the host may poll
	for (genvar c = 0; c < 4; c++)
	begin : g_settle
		dcpc_settle #(.CYCLES(SETTLE_CYCLES)) u_settle (
			.mclk_in    (mclk_in),
			.resetn_in  (resetn_in),
			.powered_in (amp_reg[c]),
			.ready_out  (settled[c])
		);
	end

	assign s_axi_awready_out       = (wst_reg == DCPC_IDLE) && !aw_got_reg;
	assign s_axi_wready_out        = (wst_reg == DCPC_IDLE) && !w_got_reg;
	assign s_axi_bvalid_out        = (wst_reg == DCPC_RESP);
	assign s_axi_bresp_out         = bresp_reg;
	assign s_axi_arready_out       = (rst_reg == DCPC_IDLE);
	assign s_axi_rvalid_out        = (rst_reg == DCPC_RESP);
	assign s_axi_rdata_out         = rdata_reg;
	assign s_axi_rresp_out         = rresp_reg;
	assign amp_connect_switch_out  = amp_reg;
	assign output_ground_clamp_out = gnd_reg;
	assign current_limit_out       = lim_reg;
	assign chan_ready_out          = settled;
	assign irq_out                 = irq_reg;
endmodule : dcpc_top

// *** hw/dcpc_pkg.sv ***
package dcpc_pkg;
	localparam int unsigned NUM_CHAN          = 4;
	// axi byte addresses
	localparam logic [7:0]  ADDR_PWR_CTRL     = 8'h08;
	localparam logic [7:0]  ADDR_CTRL         = 8'h0C;
	localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h14;
	localparam logic [7:0]  ADDR_DAC_WORD     = 8'h18;
	// serial register select value of the power control register
	localparam logic [2:0]  REG_SEL_PWR_CTRL  = 3'h2;
	// power control register layout
	localparam int unsigned PWR_PU_LSB        = 0;
	localparam int unsigned PWR_THERM_BIT     = 5;
	localparam int unsigned PWR_OC_LSB        = 7;
	// control register layout
	localparam int unsigned CTRL_THERM_EN_BIT = 2;
	localparam int unsigned CTRL_CLAMP_EN_BIT = 3;
	localparam logic [31:0] CTRL_RESET        = 32'h0000_0008;
	// irq status layout: oc events in [3:0], thermal in [4]
	localparam int unsigned IRQ_THERM_BIT     = 4;
	localparam int unsigned IRQ_WIDTH         = 5;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;
	// channel power-up settle time
	localparam int unsigned CLK_HZ            = 25000000;
	localparam int unsigned PU_TIME_US        = 10;
	localparam int unsigned PU_CYCLES         = (PU_TIME_US * (CLK_HZ / 1000000));
endpackage : dcpc_pkg

// *** hw/dcpc_sync.sv ***
`timescale 1ns/1ps
// three-stage synchroniser; change accepted when stages two and three agree
module dcpc_sync
	import dcpc_pkg::*;
#(
	parameter int unsigned WIDTH = 4
)(
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             resetn_in,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, val_reg;
	logic [WIDTH-1:0] s1_next, s2_next, s3_next, val_next;

	always_comb
	begin
		s1_next  = async_in;
		s2_next  = s1_reg;
		s3_next  = s2_reg;
		val_next = val_reg;
		for (int i = 0; i < int'(WIDTH); i++)
		begin
			if (s2_reg[i] == s3_reg[i])
				val_next[i] = s3_reg[i];
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			val_reg <= '0;
		end
		else
		begin
			s1_reg  <= s1_next;
			s2_reg  <= s2_next;
			s3_reg  <= s3_next;
			val_reg <= val_next;
		end
	end

	assign sync_out = val_reg;
endmodule : dcpc_sync

// *** hw/dcpc_settle.sv ***
`timescale 1ns/1ps
// per-channel settle timer; ready rises PU_CYCLES after power-up is granted
module dcpc_settle
	import dcpc_pkg::*;
#(
	parameter int unsigned CYCLES = PU_CYCLES
)(
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic resetn_in,
	// control
	input  wire logic powered_in,
	output logic      ready_out
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	// a zero count would leave ready stuck low
	if (CYCLES < 1)
	begin : g_bad_cycles
		$error("dcpc_settle: CYCLES must be at least one");
	end

	logic [CW-1:0] cnt_reg, cnt_next;
	logic          rdy_reg, rdy_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		rdy_next = rdy_reg;
		if (!powered_in)
		begin
			cnt_next = '0;
			rdy_next = 1'b0;
		end
		else if (!rdy_reg)
		begin
			if (cnt_reg == CW'(CYCLES - 1))
				rdy_next = 1'b1;
			else
				cnt_next = cnt_reg + CW'(1);
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			cnt_reg <= '0;
			rdy_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
		end
	end

	assign ready_out = rdy_reg;
endmodule : dcpc_settle

// *** verif/dcpc_analog_load.sv ***
`timescale 1ns/1ps
// far side of the switches: the load, with a commanded short
module dcpc_analog_load
	import dcpc_pkg::*;
(
	// stimulus
	input  wire logic [3:0] short_cmd_in,
	// switch state
	input  wire logic [3:0] amp_connect_in,
	// sense back to the block
	output logic      [3:0] chan_short_out
);
	// a disconnected amplifier drives no fault current
	assign chan_short_out = short_cmd_in & amp_connect_in;
endmodule : dcpc_analog_load

// *** verif/dcpc_top_sva.sv ***
`timescale 1ns/1ps
module dcpc_top_sva (
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	input  wire logic        s_axi_arvalid_in,
	input  wire logic        s_axi_arready_out,
	input  wire logic        s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic        s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic        supplies_good_in,
	input  wire logic [3:0]  chan_short_in,
	input  wire logic [3:0]  amp_connect_switch_out,
	input  wire logic [3:0]  output_ground_clamp_out,
	input  wire logic [3:0]  current_limit_out,
	input  wire logic [3:0]  chan_ready_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	property p_clamp_inverse;
		output_ground_clamp_out == ~amp_connect_switch_out;
	endproperty
	a_clamp_inverse: assert property (p_clamp_inverse) else $error("clamp and amp overlap");
	property p_reset_off;
		$rose(resetn_in) |-> amp_connect_switch_out == 4'h0 && output_ground_clamp_out == 4'hF;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("channel live after reset");
	// five edges of sense latency; the switch change is first seen at the sixth sample
	property p_no_supply;
		(!supplies_good_in) [*6] |-> amp_connect_switch_out == 4'h0;
	endproperty
	a_no_supply: assert property (p_no_supply) else $error("amp connected without supplies");
	property p_limit_clear;
		(chan_short_in == 4'h0) [*6] |-> current_limit_out == 4'h0;
	endproperty
	a_limit_clear: assert property (p_limit_clear) else $error("limit held without short");
	property p_settle;
		$rose(amp_connect_switch_out[0]) |-> (!chan_ready_out[0]) [*4];
	endproperty
	a_settle: assert property (p_settle) else $error("ready before settle time");
	property p_read_answer;
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_read_done;
		s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out;
	endproperty
	a_read_done: assert property (p_read_done) else $error("read answer repeated");
	property p_write_done;
		s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
	endproperty
	a_write_done: assert property (p_write_done) else $error("write answer repeated");
endmodule : dcpc_top_sva

bind dcpc_top dcpc_top_sva chk_u (
	.mclk_in(mclk_in), .resetn_in(resetn_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.supplies_good_in(supplies_good_in), .chan_short_in(chan_short_in),
	.amp_connect_switch_out(amp_connect_switch_out), .output_ground_clamp_out(output_ground_clamp_out),
	.current_limit_out(current_limit_out), .chan_ready_out(chan_ready_out)
);

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
	import dcpc_pkg::*;
;
	logic        mclk_in   = 1'b0;
	logic        resetn_in = 1'b0;
	logic [7:0]  awaddr    = 8'h00;
	logic        awvalid   = 1'b0;
	logic        awready;
	logic [31:0] wdata     = 32'h0;
	logic        wvalid    = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic [7:0]  araddr    = 8'h00;
	logic        arvalid   = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic [3:0]  short_cmd = 4'h0;
	logic [3:0]  chan_short;
	logic        overtemp  = 1'b0;
	logic        sup_good  = 1'b0;
	logic [3:0]  amp;
	logic [3:0]  clamp;
	logic [3:0]  climit;
	logic [3:0]  cready;
	logic        irq;
	int          bad_count = 0;
	int          samples_checked = 0;

	always #20 mclk_in = ~mclk_in;

	// settle shortened to 4 cycles
	dcpc_top #(.SETTLE_CYCLES(4)) dut_u (
		.mclk_in(mclk_in), .resetn_in(resetn_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
		.chan_short_in(chan_short), .overtemp_in(overtemp), .supplies_good_in(sup_good),
		.amp_connect_switch_out(amp), .output_ground_clamp_out(clamp), .current_limit_out(climit),
		.chan_ready_out(cready), .irq_out(irq)
	);

	dcpc_analog_load load_u (.short_cmd_in(short_cmd), .amp_connect_in(amp), .chan_short_out(chan_short));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// ready sampled at the falling edge, so no race with the launching edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic       aw_t;
		logic       w_t;
		logic       b_t;
		logic [1:0] resp;
		int         n;
		@(posedge mclk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do
		begin
			@(negedge mclk_in);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			resp = bresp;
			n++;
			@(posedge mclk_in);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
		end
		while (!b_t && n < 50);
		check("write answer", b_t, 1'b1);
		if (!b_t)
			tally_and_finish();
		else
			check("write resp", resp, er);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t;
		logic r_t;
		int   n;
		@(posedge mclk_in);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do
		begin
			@(negedge mclk_in);
			ar_t = arvalid && arready;
			r_t = rvalid;
			d = rdata;
			r = rresp;
			n++;
			@(posedge mclk_in);
			if (ar_t)
				arvalid <= 1'b0;
		end
		while (!r_t && n < 50);
		check("read answer", r_t, 1'b1);
		if (!r_t)
			tally_and_finish();
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(name, d, exp);
		check("read resp", r, RESP_OKAY);
	endtask : rdchk

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk_in);
		@(negedge mclk_in);
	endtask : wait_n

	task automatic sense(input logic [3:0] sh, input logic hot, input logic good);
		@(posedge mclk_in);
		short_cmd <= sh;
		overtemp <= hot;
		sup_good <= good;
		wait_n(10);
	endtask : sense

	task automatic sc_reset();
		rdchk(ADDR_PWR_CTRL, 32'h0, "power ctrl reset");
		rdchk(ADDR_CTRL, CTRL_RESET, "control reset");
		wait_n(1);
		check("amp reset", amp, 4'h0);
		check("clamp reset", clamp, 4'hF);
	endtask : sc_reset

	task automatic sc_release();
		wr(ADDR_PWR_CTRL, 32'h5, RESP_OKAY);
		wait_n(10);
		check("amp unsupplied", amp, 4'h0);
		sense(4'h0, 1'b0, 1'b1);
		check("amp no word", amp, 4'h0);
		wr(ADDR_DAC_WORD, 32'h1234, RESP_OKAY);
		wait_n(10);
		check("amp per channel", amp, 4'h5);
		check("clamp per channel", clamp, 4'hA);
		check("settled", cready, 4'h5);
		wr(ADDR_PWR_CTRL, 32'hF, RESP_OKAY);
		wait_n(10);
		check("amp all", amp, 4'hF);
	endtask : sc_release

	task automatic sc_clamp();
		wr(ADDR_IRQ_MASK, 32'h1F, RESP_OKAY);
		rdchk(ADDR_IRQ_MASK, 32'h1F, "mask");
		sense(4'h2, 1'b0, 1'b1);
		check("limit", climit, 4'h2);
		check("amp clamp mode", amp, 4'hF);
		check("irq raised", irq, 1'b1);
		rdchk(ADDR_PWR_CTRL, 32'h10F, "oc flag set");
		rdchk(ADDR_IRQ_STATUS, 32'h02, "status oc");
		sense(4'h0, 1'b0, 1'b1);
		rdchk(ADDR_PWR_CTRL, 32'h00F, "oc flag cleared");
		check("irq cleared", irq, 1'b0);
	endtask : sc_clamp

	task automatic sc_auto();
		wr(ADDR_IRQ_MASK, 32'h1B, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		sense(4'h4, 1'b0, 1'b1);
		check("amp auto", amp, 4'hB);
		check("clamp auto", clamp, 4'h4);
		check("irq masked", irq, 1'b0);
		rdchk(ADDR_PWR_CTRL, 32'h20B, "auto power-down");
		rdchk(ADDR_IRQ_STATUS, 32'h04, "status masked oc");
		sense(4'h0, 1'b0, 1'b1);
		rdchk(ADDR_PWR_CTRL, 32'h20B, "oc held");
		wr(ADDR_PWR_CTRL, 32'hF, RESP_OKAY);
		wait_n(10);
		rdchk(ADDR_PWR_CTRL, 32'h00F, "restored");
		check("amp restored", amp, 4'hF);
	endtask : sc_auto

	task automatic sc_thermal();
		logic [31:0] d;
		logic [1:0]  r;
		sense(4'h0, 1'b1, 1'b1);
		rdchk(ADDR_PWR_CTRL, 32'h00F, "thermal off");
		wr(ADDR_CTRL, 32'h4, RESP_OKAY);
		wait_n(10);
		rdchk(ADDR_PWR_CTRL, 32'h020, "thermal trip");
		check("amp thermal", amp, 4'h0);
		check("irq thermal", irq, 1'b1);
		rdchk(ADDR_IRQ_STATUS, 32'h10, "status thermal");
		// clearing the flag by a write must not work while it is set
		wr(ADDR_PWR_CTRL, 32'h0, RESP_OKAY);
		rdchk(ADDR_PWR_CTRL, 32'h020, "thermal read-only");
		sense(4'h0, 1'b0, 1'b1);
		rdchk(ADDR_PWR_CTRL, 32'h0, "thermal cleared");
		wr(8'h40, 32'hFFFFFFFF, RESP_SLVERR);
		rd(8'h40, d, r);
		check("unmapped data", d, 32'h0);
		check("unmapped resp", r, RESP_SLVERR);
	endtask : sc_thermal

	initial
	begin
		repeat (6) @(posedge mclk_in);
		resetn_in <= 1'b1;
		sc_reset();
		sc_release();
		sc_clamp();
		sc_auto();
		sc_thermal();
		tally_and_finish();
	end
endmodule : tb_top
